//--- fpled_top.sv
/*
 * Front-panel indicator controller. Software writes two-bit fields for
 * the system LEDs; each field bit is 0 (lit) or 1 (dark), except that a
 * 00 field selects a blink code and fan code 01 is dark. Port and
 * fan-tray LEDs follow status inputs directly.
 * Assumes a 250 MHz clock, a synchronous active-high reset, pin status
 * inputs asynchronous to the clock, and active-low LED drive.
 */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fpled_map.svh"

module fpled_top #(
  parameter int unsigned N_COPPER = 5,
  parameter int unsigned N_SFP    = 16,
  parameter int unsigned N_SFPP   = 8,
  parameter int unsigned N_FAN    = 3,
  parameter int unsigned FAST_HALF = `FPLED_FAST_HALF,
  parameter int unsigned SLOW_HALF = `FPLED_SLOW_HALF
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [`FPLED_ADDR_W-1:0] reg_addr_in,
  input  wire logic [`FPLED_DATA_W-1:0] reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [`FPLED_DATA_W-1:0] reg_rdata_out,
  input  wire logic [N_COPPER-1:0]      cu_link_in,
  input  wire logic [N_COPPER-1:0]      cu_gig_in,
  input  wire logic [N_COPPER-1:0]      cu_tx_in,
  input  wire logic [N_SFP-1:0]         sfp_link_in,
  input  wire logic [N_SFP-1:0]         sfp_gig_in,
  input  wire logic [N_SFP-1:0]         sfp_tx_in,
  input  wire logic [N_SFPP-1:0]        sfpp_link_in,
  input  wire logic [N_SFPP-1:0]        sfpp_tengig_in,
  input  wire logic [N_SFPP-1:0]        sfpp_tx_in,
  input  wire logic [N_FAN-1:0]         fan_present_n_in,
  input  wire logic [N_FAN-1:0]         fan_int_n_in,
  input  wire logic                     board_power_good_in,
  output logic      [5:0]               sys_led_n_out,
  output logic      [3:0]               ts_led_n_out,
  output logic      [N_COPPER-1:0]      cu_green_n_out,
  output logic      [N_COPPER-1:0]      cu_yellow_n_out,
  output logic      [N_SFP-1:0]         sfp_green_n_out,
  output logic      [N_SFP-1:0]         sfp_yellow_n_out,
  output logic      [N_SFPP-1:0]        sfpp_green_n_out,
  output logic      [N_SFPP-1:0]        sfpp_yellow_n_out,
  output logic      [N_FAN-1:0]         fan_green_n_out,
  output logic      [N_FAN-1:0]         fan_yellow_n_out
);

  // ****************************************************************
  // Blink sources
  // ****************************************************************

  logic fast_blink;
  logic slow_blink;

  // Two independent dividers give the 1 Hz and 0.5 Hz patterns.
  fpled_blink_div #(.HALF(FAST_HALF)) u_fast (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .wave_out   (fast_blink)
  );

  fpled_blink_div #(.HALF(SLOW_HALF)) u_slow (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .wave_out   (slow_blink)
  );

  // ****************************************************************
  // Register port
  // ****************************************************************

  localparam int unsigned NP = N_COPPER + N_SFP + N_SFPP;
  localparam int unsigned NS = 3 * NP + 2 * N_FAN + 1;

  logic [`FPLED_DATA_W-1:0] ctrl_reg;
  logic [`FPLED_DATA_W-1:0] ctrl_next;
  logic [`FPLED_DATA_W-1:0] rdata_reg;
  logic [`FPLED_DATA_W-1:0] rdata_next;
  logic [NS-1:0]            pin_meta_reg;
  logic [NS-1:0]            pin_sync_reg;
  logic [NS-1:0]            pin_raw;

  // Whole control word is stored, so undefined bits read back as written.
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = '0;
    if (reg_wr_in && reg_addr_in == `FPLED_CTRL_ADDR)
      ctrl_next = reg_wdata_in;
    if (reg_rd_in)
    begin
      if (reg_addr_in == `FPLED_CTRL_ADDR)
        rdata_next = ctrl_reg;
      else if (reg_addr_in == `FPLED_STAT_ADDR)
        rdata_next = {{(`FPLED_DATA_W - 2 * N_FAN){1'b0}},
                      fan_yellow_n_out, fan_green_n_out};
    end
  end

  // Control resets to all indicators dark.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_reg  <= `FPLED_CTRL_RESET;
      rdata_reg <= '0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  assign pin_raw = {board_power_good_in, fan_int_n_in, fan_present_n_in,
                    sfpp_tx_in, sfpp_tengig_in, sfpp_link_in,
                    sfp_tx_in, sfp_gig_in, sfp_link_in,
                    cu_tx_in, cu_gig_in, cu_link_in};

  // Two flops before any logic reads a pin.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic [N_COPPER-1:0] s_cu_link, s_cu_gig, s_cu_tx;
  logic [N_SFP-1:0]    s_sfp_link, s_sfp_gig, s_sfp_tx;
  logic [N_SFPP-1:0]   s_sfpp_link, s_sfpp_ten, s_sfpp_tx;
  logic [N_FAN-1:0]    s_fan_prs_n, s_fan_int_n;
  logic                s_power_good;

  assign {s_power_good, s_fan_int_n, s_fan_prs_n,
          s_sfpp_tx, s_sfpp_ten, s_sfpp_link,
          s_sfp_tx, s_sfp_gig, s_sfp_link,
          s_cu_tx, s_cu_gig, s_cu_link} = pin_sync_reg;

  // ****************************************************************
  // System and timing indicators
  // ****************************************************************

  logic [5:0] sys_next;
  logic [3:0] ts_next;
  logic [5:0] sys_reg;
  logic [3:0] ts_reg;

  // Blink is encoded by the both-lit pattern: a field where both bits are
  // zero is a blink code. Only masked bits are decoded.
  always_comb
  begin
    logic [1:0] f;
    f = '0;
    // Power: 00 holds green lit and toggles the yellow pin.
    f = ctrl_reg[`FPLED_POWER_LSB +: 2];
    sys_next[0] = f[0];
    sys_next[1] = f[1];
    if (f == 2'b00)
    begin
      sys_next[0] = 1'b0;
      sys_next[1] = fast_blink;
    end
    // Fan: only steady green and blinking yellow exist; the rest is dark.
    f = ctrl_reg[`FPLED_FAN_LSB +: 2];
    sys_next[2] = 1'b1;
    sys_next[3] = 1'b1;
    if (f == 2'b10)
      sys_next[2] = 1'b0;
    else if (f == 2'b00)
      sys_next[3] = slow_blink;
    f = ctrl_reg[`FPLED_STATE_LSB +: 2];
    sys_next[4] = f[0];
    sys_next[5] = f[1];
    if (f == 2'b00)
    begin
      sys_next[4] = fast_blink;
      sys_next[5] = 1'b1;
    end
    f = ctrl_reg[`FPLED_SAT_LSB +: 2];
    ts_next[0] = f[0];
    ts_next[1] = f[1];
    if (f == 2'b00)
    begin
      ts_next[0] = fast_blink;
      ts_next[1] = 1'b1;
    end
    f = ctrl_reg[`FPLED_SYNC_LSB +: 2];
    ts_next[2] = f[0];
    ts_next[3] = f[1];
    if (f == 2'b00)
    begin
      ts_next[2] = 1'b1;
      ts_next[3] = fast_blink;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sys_reg <= 6'h3f;
      ts_reg  <= 4'hf;
    end
    else
    begin
      sys_reg <= sys_next;
      ts_reg  <= ts_next;
    end
  end

  assign sys_led_n_out = sys_reg;
  assign ts_led_n_out  = ts_reg;

  // ****************************************************************
  // Port indicators
  // ****************************************************************

  logic [NP-1:0] p_link, p_fast, p_tx, p_g, p_y;

  assign p_link = {s_sfpp_link, s_sfp_link, s_cu_link};
  assign p_fast = {s_sfpp_ten, s_sfp_gig, s_cu_gig};
  assign p_tx   = {s_sfpp_tx, s_sfp_tx, s_cu_tx};

  for (genvar i = 0; i < NP; i++)
  begin : g_port
    fpled_port_led u_led (
      .ref_clk_in   (ref_clk_in),
      .sys_rst_in   (sys_rst_in),
      .link_in      (p_link[i]),
      .fast_in      (p_fast[i]),
      .tx_in        (p_tx[i]),
      .blink_in     (fast_blink),
      .green_n_out  (p_g[i]),
      .yellow_n_out (p_y[i])
    );
  end

  assign {sfpp_green_n_out, sfp_green_n_out, cu_green_n_out}    = p_g;
  assign {sfpp_yellow_n_out, sfp_yellow_n_out, cu_yellow_n_out} = p_y;

  // ****************************************************************
  // Fan tray indicators
  // ****************************************************************

  logic [N_FAN-1:0] fg_next, fy_next, fg_reg, fy_reg;

  // Dark when absent or board power failed; interrupt gives yellow blink.
  always_comb
  begin
    for (int k = 0; k < N_FAN; k++)
    begin
      fg_next[k] = 1'b1;
      fy_next[k] = 1'b1;
      if (s_power_good && !s_fan_prs_n[k])
      begin
        if (s_fan_int_n[k])
          fg_next[k] = 1'b0;
        else
          fy_next[k] = slow_blink;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      fg_reg <= '1;
      fy_reg <= '1;
    end
    else
    begin
      fg_reg <= fg_next;
      fy_reg <= fy_next;
    end
  end

  assign fan_green_n_out  = fg_reg;
  assign fan_yellow_n_out = fy_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [1:0]       power_code;
  logic [N_FAN-1:0] fan_live;
  // Plain views of the power field and of the fans that may light.
  assign power_code = ctrl_reg[`FPLED_POWER_LSB +: 2];
  assign fan_live   = ~s_fan_prs_n & {N_FAN{s_power_good}};

  // Blink code held first, then green lit beside a toggling yellow pin.
  sequence s_power_blink_set;
    power_code == 2'b00;
  endsequence
  sequence s_power_blink_shown;
    !sys_led_n_out[0] && sys_led_n_out[1] == $past(fast_blink);
  endsequence

  // Register port: a write lands and a read returns the stored word.
  a_ctrl_write_lands: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) reg_wr_in && reg_addr_in == `FPLED_CTRL_ADDR
    |=> ctrl_reg == $past(reg_wdata_in)) else $error("control write lost");
  a_ctrl_read_back: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) reg_rd_in && reg_addr_in == `FPLED_CTRL_ADDR
    |=> reg_rdata_out == $past(ctrl_reg)) else $error("control read wrong");

  // Power pins follow the power field; fan tray pins stay dark when not live.
  a_power_steady_code: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) power_code != 2'b00
    |=> sys_led_n_out[1:0] == $past(power_code))
    else $error("power pins differ from the steady code");
  a_power_blink_code: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) s_power_blink_set |=> s_power_blink_shown)
    else $error("power blink pattern missing");
  a_fan_tray_dark: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) 1'b1
    |=> ((fan_green_n_out & fan_yellow_n_out) | $past(fan_live)) == '1)
    else $error("fan tray indicator lit while absent or unpowered");

endmodule

`default_nettype wire

//--- fpled_map.svh
/*
 * Register map, field positions, reset values and blink timing for the
 * front-panel indicator block, all held as text macros.
 * Assumes a single 250 MHz system clock and a plain register port.
 */
// Overview of operation
// - Power field bits 0-1, low green, high yellow
// - Power steady: off, solid green, solid yellow
// - Power blinking green 1Hz, yellow 0.5Hz; code 00 keeps green lit and blinks yellow at 1Hz
// - Fan field bits 2-3, green or blinking
// - System state field bits 4-5
// - Satellite receiver field bits 8-9
// - Synchronization field bits 10-11
// - Sync bit10 one, bit11 blinking: yellow blink
// - Fan tray LED follows presence and interrupt
// - Copper and out-of-band port link/activity LEDs
// - Small-form-factor port link/activity LEDs
// - Enhanced small-form-factor port link/activity LEDs
`ifndef FPLED_MAP_SVH
`define FPLED_MAP_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FPLED_ADDR_W        4
`define FPLED_DATA_W        16
`define FPLED_CTRL_ADDR     4'h0
`define FPLED_STAT_ADDR     4'h1
`define FPLED_CTRL_RESET    16'h0fff

// ****************************************************************
// Field positions, each field is two bits wide
// ****************************************************************
`define FPLED_POWER_LSB     0
`define FPLED_FAN_LSB       2
`define FPLED_STATE_LSB     4
`define FPLED_SAT_LSB       8
`define FPLED_SYNC_LSB      10
`define FPLED_FIELD_MASK    16'h0f3f

// ****************************************************************
// Blink timing
// ****************************************************************
`define FPLED_CLK_HZ        250000000
`define FPLED_FAST_HZ       1
`define FPLED_SLOW_HZ_X10   5
`define FPLED_FAST_HALF     (`FPLED_CLK_HZ / (2 * `FPLED_FAST_HZ))
// Folded so the product stays inside a 32-bit integer.
`define FPLED_SLOW_HALF     ((`FPLED_CLK_HZ * 5) / `FPLED_SLOW_HZ_X10)

`endif

//--- fpled_pkg.sv
/*
 * Types shared by the front-panel indicator block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpled_pkg;

  // Drive of one port indicator derived from link state.
  typedef enum logic [1:0] {
    FPLED_SPEED_NONE,
    FPLED_SPEED_GREEN,
    FPLED_SPEED_YELLOW
  } fpled_speed_t;

endpackage

//--- fpled_blink_div.sv
/*
 * Blink divider: a free-running counter that toggles a square wave each
 * time it reaches its half-period terminal count.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module fpled_blink_div #(
  parameter int unsigned HALF = 125000000
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  output logic      wave_out
);

  localparam int unsigned CW = $clog2(HALF + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          wave_reg;
  logic          wave_next;

  // Count to the terminal value and flip the wave there.
  always_comb
  begin
    cnt_next  = cnt_reg + CW'(1);
    wave_next = wave_reg;
    if (cnt_reg == CW'(HALF - 1))
    begin
      cnt_next  = '0;
      wave_next = ~wave_reg;
    end
  end

  // Both counter and wave clear on reset.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_reg  <= '0;
      wave_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      wave_reg <= wave_next;
    end
  end

  // The wave may move only at the terminal count, and must move there.
  a_blink_flip: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) cnt_reg == CW'(HALF - 1)
    |=> wave_reg != $past(wave_reg)) else $error("blink wave did not flip");
  a_blink_hold: assert property (@(posedge ref_clk_in)
    disable iff (sys_rst_in) cnt_reg != CW'(HALF - 1)
    |=> $stable(wave_reg)) else $error("blink wave moved early");

  assign wave_out = wave_reg;

endmodule

`default_nettype wire

//--- fpled_port_led.sv
/*
 * One port link/activity indicator: colour from link speed, blink while
 * transmitting. LED drive is active low, matching the panel fields.
 * Assumes link inputs are already synchronised to the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module fpled_port_led (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic link_in,
  input  wire logic fast_in,
  input  wire logic tx_in,
  input  wire logic blink_in,
  output logic      green_n_out,
  output logic      yellow_n_out
);

  fpled_pkg::fpled_speed_t sel;
  logic                    g_next;
  logic                    y_next;
  logic                    g_reg;
  logic                    y_reg;

  // Off with no link; colour from speed; blinking while transmitting.
  always_comb
  begin
    sel = !link_in ? fpled_pkg::FPLED_SPEED_NONE :
          fast_in ? fpled_pkg::FPLED_SPEED_GREEN :
          fpled_pkg::FPLED_SPEED_YELLOW;
    g_next = 1'b1;
    y_next = 1'b1;
    if (sel == fpled_pkg::FPLED_SPEED_GREEN)
      g_next = tx_in ? blink_in : 1'b0;
    else if (sel == fpled_pkg::FPLED_SPEED_YELLOW)
      y_next = tx_in ? blink_in : 1'b0;
  end

  // Register the drive so outputs come from flip-flops.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      g_reg <= 1'b1;
      y_reg <= 1'b1;
    end
    else
    begin
      g_reg <= g_next;
      y_reg <= y_next;
    end
  end

  assign green_n_out  = g_reg;
  assign yellow_n_out = y_reg;

endmodule

`default_nettype wire

//--- fpled_panel_model.sv
/*
 * Panel model: notes for every LED whether it was seen lit and seen
 * dark since the last clear, so one window tells off, solid and blink.
 * Assumes active-low LED drive sampled on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module fpled_panel_model #(
  parameter int unsigned W = 74
) (
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] led_n_in,
  output logic      [W-1:0] seen_lit_out,
  output logic      [W-1:0] seen_dark_out
);
  // Sticky flags; a blinking LED ends the window with both flags set.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || clear_in)
    begin
      seen_lit_out  <= '0;
      seen_dark_out <= '0;
    end
    else
    begin
      seen_lit_out  <= seen_lit_out | ~led_n_in;
      seen_dark_out <= seen_dark_out | led_n_in;
    end
  end
endmodule
`default_nettype wire

//--- front_panel_led_control_tb.sv
/*
 * Self-checking bench for the front-panel indicator block: random and
 * hand-picked control words and port, fan and power states.
 * Assumes short blink half periods of 4 and 8 clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module front_panel_led_control_tb;
  localparam int NC = 5;
  localparam int NS = 16;
  localparam int NP = 8;
  localparam int NF = 3;
  localparam int NU = 5 + NC + NS + NP + NF;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0;
  logic pg = 1'b1;
  logic [3:0] addr = '0;
  logic [15:0] wdata = '0, rdata, got;
  logic [NC-1:0] cu_l = '0, cu_g = '0, cu_t = '0, cu_gn, cu_yn;
  logic [NS-1:0] sf_l = '0, sf_g = '0, sf_t = '0, sf_gn, sf_yn;
  logic [NP-1:0] sp_l = '0, sp_g = '0, sp_t = '0, sp_gn, sp_yn;
  logic [NF-1:0] fa_p = '1, fa_i = '1, fa_gn, fa_yn;
  logic [5:0] sys_n;
  logic [3:0] ts_n;
  logic [2*NU-1:0] leds, lit, dark, e_lit, e_dark;
  int n_errors = 0, checked = 0, cyc = 0;

  // ******************************************************************
  // Clock, design and panel
  // ******************************************************************
  always #2 clk = ~clk;

  fpled_top #(.FAST_HALF(4), .SLOW_HALF(8)) dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .cu_link_in(cu_l), .cu_gig_in(cu_g), .cu_tx_in(cu_t),
    .sfp_link_in(sf_l), .sfp_gig_in(sf_g), .sfp_tx_in(sf_t),
    .sfpp_link_in(sp_l), .sfpp_tengig_in(sp_g), .sfpp_tx_in(sp_t),
    .fan_present_n_in(fa_p), .fan_int_n_in(fa_i),
    .board_power_good_in(pg),
    .sys_led_n_out(sys_n), .ts_led_n_out(ts_n),
    .cu_green_n_out(cu_gn), .cu_yellow_n_out(cu_yn),
    .sfp_green_n_out(sf_gn), .sfp_yellow_n_out(sf_yn),
    .sfpp_green_n_out(sp_gn), .sfpp_yellow_n_out(sp_yn),
    .fan_green_n_out(fa_gn), .fan_yellow_n_out(fa_yn)
  );

  // Every indicator becomes one {yellow, green} pair on the panel.
  always_comb
  begin
    leds[9:0] = {ts_n, sys_n};
    for (int i = 0; i < NC; i++)
      leds[2*(5+i)+:2] = {cu_yn[i], cu_gn[i]};
    for (int i = 0; i < NS; i++)
      leds[2*(5+NC+i)+:2] = {sf_yn[i], sf_gn[i]};
    for (int i = 0; i < NP; i++)
      leds[2*(5+NC+NS+i)+:2] = {sp_yn[i], sp_gn[i]};
    for (int i = 0; i < NF; i++)
      leds[2*(5+NC+NS+NP+i)+:2] = {fa_yn[i], fa_gn[i]};
  end

  fpled_panel_model #(.W(2*NU)) panel_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .clear_in(clr),
    .led_n_in(leds), .seen_lit_out(lit), .seen_dark_out(dark)
  );

  // ******************************************************************
  // Expectations, each as {yellow on, yellow blinks, green on, blinks}
  // ******************************************************************
  function automatic logic [3:0] fld(input logic [1:0] c, input logic yb);
    if (c == 2'b00)
      return yb ? 4'b1100 : 4'b0011;
    return {~c[1], 1'b0, ~c[0], 1'b0};
  endfunction

  // A port lights its speed colour while linked and blinks it on traffic.
  function automatic logic [3:0] prt(input logic l, g, t);
    if (!l)
      return 4'b0000;
    return g ? {2'b00, 1'b1, t} : {1'b1, t, 2'b00};
  endfunction

  function automatic logic [3:0] fan(input logic p_n, i_n, ok);
    if (p_n || !ok)
      return 4'b0000;
    return i_n ? 4'b0010 : 4'b1100;
  endfunction

  task automatic put(input int u, input logic [3:0] f);
    e_lit[2*u] = f[1];
    e_dark[2*u] = !f[1] || f[0];
    e_lit[2*u+1] = f[3];
    e_dark[2*u+1] = !f[3] || f[2];
  endtask

  task automatic expect_all(input logic [15:0] c);
    put(0, c[1:0] == 2'b00 ? 4'b1110 : fld(c[1:0], 1'b0));
    put(1, c[3:2] == 2'b01 ? 4'b0000 : fld(c[3:2], 1'b1));
    put(2, fld(c[5:4], 1'b0));
    put(3, fld(c[9:8], 1'b0));
    put(4, fld(c[11:10], 1'b1));
    for (int i = 0; i < NC; i++)
      put(5 + i, prt(cu_l[i], cu_g[i], cu_t[i]));
    for (int i = 0; i < NS; i++)
      put(5 + NC + i, prt(sf_l[i], sf_g[i], sf_t[i]));
    for (int i = 0; i < NP; i++)
      put(5 + NC + NS + i, prt(sp_l[i], sp_g[i], sp_t[i]));
    for (int i = 0; i < NF; i++)
      put(5 + NC + NS + NP + i, fan(fa_p[i], fa_i[i], pg));
  endtask

  // ******************************************************************
  // Bus, comparison and closing tasks
  // ******************************************************************
  task automatic chk(input string nm, input logic [79:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rdreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Settle, clear the panel, then watch long enough for a slow blink.
  task automatic observe(input logic [15:0] c);
    repeat (5) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (24) @(posedge clk);
    #1 expect_all(c);
    chk("lit", 80'(lit), 80'(e_lit));
    chk("dark", 80'(dark), 80'(e_dark));
  endtask

  task automatic round(input logic [15:0] c);
    logic [NF-1:0] on_g, on_y;
    wrreg(4'h0, c);
    @(posedge clk);
    {cu_l, cu_g, cu_t} <= 15'($urandom);
    {sf_l, sf_g} <= $urandom;
    sf_t <= NS'($urandom);
    {sp_l, sp_g, sp_t} <= 24'($urandom);
    {fa_p, fa_i, pg} <= 7'($urandom);
    observe(c);
    rdreg(4'h0, got);
    chk("ctrl", 80'(got), 80'(c));
    // Fan status word: green bits exact, yellow dark unless blinking.
    for (int i = 0; i < NF; i++)
    begin
      on_g[i] = !fa_p[i] && pg && fa_i[i];
      on_y[i] = !fa_p[i] && pg && !fa_i[i];
    end
    rdreg(4'h1, got);
    got = got | {10'h0, on_y, 3'h0};
    chk("fan status", 80'(got), 80'({13'h007, ~on_g}));
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    void'($urandom(32'h4a0472dd));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdreg(4'h0, got);
    chk("ctrl reset", 80'(got), 80'h0fff);
    observe(16'h0fff);
    wrreg(4'h7, 16'h1234);
    rdreg(4'h0, got);
    chk("ctrl kept", 80'(got), 80'h0fff);
    rdreg(4'h9, got);
    chk("unmapped", 80'(got), 80'h0);
    round(16'h0000);
    round(16'hf555);
    round(16'h30aa);
    round(16'h0c0f);
    for (int i = 0; i < 14; i++)
      round(16'($urandom));
    report_and_stop();
  end
endmodule
`default_nettype wire
